// *** hdl/pcbrk_pkg.sv ***
// Package of constants for the program-counter break match channel.
//------------------------------------------------------------------
// Summary of operation
// - Match flag sets when the selected condition is met and stays set until cleared.
// - Cycle-select value 001 makes CPU-initiated bus cycles eligible.
// - Break-source value 01 makes an instruction fetch at the address the source.
// - Read-select field decides whether read cycles qualify.
// - Handler software clears the match flag by writing zero to it.
// - Stop bit at 1 holds the unit stopped; 0 restores operation.
//------------------------------------------------------------------
package pcbrk_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses.
  // ---------------------------------------------------------------
  localparam logic [23:0] PCBRK_ADDR_OFS   = 24'hfffa00;
  localparam logic [23:0] PCBRK_CTRL_OFS   = 24'hfffa28;
  localparam logic [23:0] PCBRK_STOP_OFS   = 24'hfffa40;
  localparam logic [23:0] PCBRK_STAT_OFS   = 24'hfffa44;
  localparam logic [23:0] PCBRK_IEN_OFS    = 24'hfffa48;
  localparam logic [23:0] PCBRK_ICLR_OFS   = 24'hfffa4c;

  // ---------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------
  localparam int          PCBRK_CMF_BIT    = 15;
  localparam int          PCBRK_CYC_LSB    = 9;
  localparam int          PCBRK_SRC_LSB    = 4;
  localparam int          PCBRK_RD_LSB     = 2;
  localparam logic [2:0]  PCBRK_CYC_CPU    = 3'h1;
  localparam logic [1:0]  PCBRK_SRC_PC     = 2'h1;
  localparam logic [1:0]  PCBRK_RD_ANY     = 2'h0;
  localparam logic [1:0]  PCBRK_RD_READ    = 2'h1;
  localparam logic [1:0]  PCBRK_RD_WRITE   = 2'h2;
  localparam logic [15:0] PCBRK_CTRL_MASK  = 16'h8e3c;

  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [31:0] PCBRK_ADDR_RST   = 32'h00000000;
  localparam logic [15:0] PCBRK_CTRL_RST   = 16'h0000;
  localparam logic        PCBRK_STOP_RST   = 1'b1;

  // Interrupt status bits: 0 break request, 1 stop-bit write while the match flag is set.
  localparam int          PCBRK_NEV        = 2;

endpackage : pcbrk_pkg

// *** hdl/pcbrk_match.sv ***
// Address and cycle-type comparator of the break channel.
`timescale 1ns/1ps
`default_nettype none
module pcbrk_match
  import pcbrk_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] brk_addr,
  input  wire logic [15:0]   ctrl,
  input  wire logic          cyc_valid,
  input  wire logic [AW-1:0] cyc_addr,
  input  wire logic          cyc_cpu,
  input  wire logic          cyc_fetch,
  input  wire logic          cyc_read,
  output logic               hit
);

  logic [2:0] cyc_sel;
  logic [1:0] src_sel;
  logic [1:0] rd_sel;
  logic       addr_ok;
  logic       type_ok;
  logic       src_ok;
  logic       rd_ok;

  // Field extraction and per-term qualification.
  assign cyc_sel = ctrl[PCBRK_CYC_LSB+2:PCBRK_CYC_LSB];
  assign src_sel = ctrl[PCBRK_SRC_LSB+1:PCBRK_SRC_LSB];
  assign rd_sel  = ctrl[PCBRK_RD_LSB+1:PCBRK_RD_LSB];
  assign addr_ok = (cyc_addr == brk_addr);
  assign type_ok = (cyc_sel == PCBRK_CYC_CPU) && cyc_cpu;
  assign src_ok  = (src_sel == PCBRK_SRC_PC) && cyc_fetch;

  // Read-select qualification; other codes never qualify.
  always_comb begin
    case (rd_sel)
      PCBRK_RD_ANY:   rd_ok = 1'b1;
      PCBRK_RD_READ:  rd_ok = cyc_read;
      PCBRK_RD_WRITE: rd_ok = !cyc_read;
      default:        rd_ok = 1'b0;
    endcase
  end

  // All enabled terms must agree in the same cycle.
  assign hit = cyc_valid && addr_ok && type_ok && src_ok && rd_ok;

endmodule : pcbrk_match
`default_nettype wire

// *** hdl/pcbrk_channel.sv ***
// Top of the program-counter break match channel with its register slave.
`timescale 1ns/1ps
`default_nettype none
module pcbrk_channel
  import pcbrk_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic [23:0]   avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          cyc_valid,
  input  wire logic [AW-1:0] cyc_addr,
  input  wire logic          cyc_cpu,
  input  wire logic          cyc_fetch,
  input  wire logic          cyc_read,
  output logic               break_req,
  output logic               irq
);

  //----------------------------------------------------------------
  // Register state.
  //----------------------------------------------------------------
  logic [AW-1:0]        addr_r,  addr_nxt;
  logic [15:0]          ctrl_r,  ctrl_nxt;
  logic                 stop_r,  stop_nxt;
  logic [PCBRK_NEV-1:0] stat_r,  stat_nxt;
  logic [PCBRK_NEV-1:0] ien_r,   ien_nxt;
  logic                 ack_r,   ack_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic                 brk_r,   brk_nxt;

  logic                 hit;
  logic                 wr_go;
  logic                 rd_go;
  logic [31:0]          wmask;
  logic [PCBRK_NEV-1:0] ev;

  // Byte enables widened to a bit mask.
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // One wait state per access: the answer comes at the second edge.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go           = avs_write && ack_r;
  assign rd_go           = avs_read && !ack_r;

  //----------------------------------------------------------------
  // Comparator.
  //----------------------------------------------------------------
  pcbrk_match #(
    .AW (AW)
  ) u_match (
    .brk_addr  (addr_r),
    .ctrl      (ctrl_r),
    .cyc_valid (cyc_valid && !stop_r),
    .cyc_addr  (cyc_addr),
    .cyc_cpu   (cyc_cpu),
    .cyc_fetch (cyc_fetch),
    .cyc_read  (cyc_read),
    .hit       (hit)
  );

  // Interrupt events: a break, or a stop request while a match is pending.
  assign ev[0] = hit;
  assign ev[1] = wr_go && (avs_address == PCBRK_STOP_OFS) && avs_byteenable[0]
                 && avs_writedata[0] && ctrl_r[PCBRK_CMF_BIT];

  //----------------------------------------------------------------
  // Next-state logic of registers and the bus slave.
  //----------------------------------------------------------------
  always_comb begin
    addr_nxt  = addr_r;
    ctrl_nxt  = ctrl_r;
    stop_nxt  = stop_r;
    stat_nxt  = stat_r;
    ien_nxt   = ien_r;
    ack_nxt   = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    brk_nxt   = 1'b0;
    if (wr_go) begin
      case (avs_address)
        PCBRK_ADDR_OFS: begin
          addr_nxt = (addr_r & ~wmask[AW-1:0]) | (avs_writedata[AW-1:0] & wmask[AW-1:0]);
        end
        PCBRK_CTRL_OFS: begin
          // The flag only accepts a zero; a one written there is ignored.
          ctrl_nxt = (ctrl_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
          ctrl_nxt = ctrl_nxt & PCBRK_CTRL_MASK;
          ctrl_nxt[PCBRK_CMF_BIT] = ctrl_r[PCBRK_CMF_BIT] &&
                                    (avs_writedata[PCBRK_CMF_BIT] || !avs_byteenable[1]);
        end
        PCBRK_STOP_OFS: begin
          if (avs_byteenable[0]) begin
            stop_nxt = avs_writedata[0];
          end
        end
        PCBRK_IEN_OFS: begin
          if (avs_byteenable[0]) begin
            ien_nxt = avs_writedata[PCBRK_NEV-1:0];
          end
        end
        PCBRK_ICLR_OFS: begin
          if (avs_byteenable[0]) begin
            stat_nxt = stat_r & ~avs_writedata[PCBRK_NEV-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a software clear in the same cycle.
    stat_nxt = stat_nxt | ev;
    if (hit) begin
      ctrl_nxt[PCBRK_CMF_BIT] = 1'b1;
      brk_nxt = 1'b1;
    end
    if (rd_go) begin
      case (avs_address)
        PCBRK_ADDR_OFS: rdata_nxt = 32'(addr_r);
        PCBRK_CTRL_OFS: rdata_nxt = {16'h0000, ctrl_r};
        PCBRK_STOP_OFS: rdata_nxt = {31'h00000000, stop_r};
        PCBRK_STAT_OFS: rdata_nxt = 32'(stat_r);
        PCBRK_IEN_OFS:  rdata_nxt = 32'(ien_r);
        default:        rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Register update.
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_r  <= PCBRK_ADDR_RST[AW-1:0];
      ctrl_r  <= PCBRK_CTRL_RST;
      stop_r  <= PCBRK_STOP_RST;
      stat_r  <= '0;
      ien_r   <= '0;
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
      brk_r   <= 1'b0;
    end else begin
      addr_r  <= addr_nxt;
      ctrl_r  <= ctrl_nxt;
      stop_r  <= stop_nxt;
      stat_r  <= stat_nxt;
      ien_r   <= ien_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
      brk_r   <= brk_nxt;
    end
  end

  // Outputs.
  assign avs_readdata = rdata_r;
  assign break_req    = brk_r;
  assign irq          = |(stat_r & ien_r);

endmodule : pcbrk_channel
`default_nettype wire

// *** tb/pcbrk_channel_sva.sv ***
// Checker of the break channel's register bus and break request.
`timescale 1ns/1ps
`default_nettype none
module pcbrk_channel_sva
  import pcbrk_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [23:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        cyc_valid,
  input wire logic        cyc_cpu,
  input wire logic        cyc_fetch,
  input wire logic        break_req,
  input wire logic        irq
);
  //----------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
  property p_new_wait; $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest; endproperty
  a_new_wait: assert property (p_new_wait) else $error("request not held off");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait without request");
  property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_clr_zero; avs_read && !avs_waitrequest && avs_address == PCBRK_ICLR_OFS
    |-> avs_readdata == 32'h0; endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear register not zero");
  property p_cause; break_req |-> $past(cyc_valid && cyc_cpu && cyc_fetch); endproperty
  a_cause: assert property (p_cause) else $error("break without fetch");
  property p_quiet; $fell(reset) |-> (!break_req && !irq) [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("break after reset");
  property p_irq; $rose(irq) |-> break_req || $past(avs_write && !avs_waitrequest); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : pcbrk_channel_sva
bind pcbrk_channel pcbrk_channel_sva i_sva (.clock, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .cyc_valid, .cyc_cpu, .cyc_fetch,
  .break_req, .irq);
`default_nettype wire

// *** tb/pcbrk_cpu_model.sv ***
// Behavioural CPU that issues single bus cycles and counts break requests.
`timescale 1ns/1ps
`default_nettype none
module pcbrk_cpu_model (
  input  wire logic        clock,
  input  wire logic        issue,
  input  wire logic [31:0] addr,
  input  wire logic [2:0]  kind,
  input  wire logic        break_req,
  output logic             cyc_valid,
  output logic [31:0]      cyc_addr,
  output logic             cyc_cpu,
  output logic             cyc_fetch,
  output logic             cyc_read,
  output int               brk_cnt
);
  // Idle cycles show a changing pattern so a stale address never looks valid.
  initial begin
    {cyc_valid, cyc_addr, cyc_cpu, cyc_fetch, cyc_read} = '0;
    brk_cnt = 0;
  end
  always @(posedge clock) begin
    cyc_valid <= issue;
    cyc_addr <= issue ? addr : ~cyc_addr;
    {cyc_cpu, cyc_fetch, cyc_read} <= issue ? kind : ~{cyc_cpu, cyc_fetch, cyc_read};
    if (break_req === 1'b1) brk_cnt <= brk_cnt + 1;
  end
endmodule : pcbrk_cpu_model
`default_nettype wire

// *** tb/pcbrk_channel_tb_top.sv ***
// Self-checking bench of the break match channel.
`timescale 1ns/1ps
`default_nettype none
module pcbrk_channel_tb_top;
  import pcbrk_pkg::*;
  localparam logic [31:0] BRK = 32'h00001400;
  localparam logic [31:0] CFG = 32'({PCBRK_CYC_CPU, 3'h0, PCBRK_SRC_PC, 4'h0});
  logic        clock, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, issue = 1'b0;
  logic [23:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, addr = '0, cyc_addr;
  logic [2:0]  kind = '0;
  logic        avs_waitrequest, cyc_valid, cyc_cpu, cyc_fetch, cyc_read, break_req, irq;
  int          brk_cnt, error_cnt = 0, check_count = 0;
  pcbrk_channel i_dut (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .cyc_valid, .cyc_addr, .cyc_cpu,
    .cyc_fetch, .cyc_read, .break_req, .irq);
  pcbrk_cpu_model i_cpu (.clock, .issue, .addr, .kind, .break_req, .cyc_valid, .cyc_addr,
    .cyc_cpu, .cyc_fetch, .cyc_read, .brk_cnt);
  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      error_cnt++;
    end
  endtask : chk
  // One bus transfer; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      chk("waitrequest", 32'h0, 32'h1);
      conclude();
    end
    @(posedge clock);
  endtask : bus
  task automatic rchk(input logic [23:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk
  // Issue one bus cycle and count the breaks it causes.
  task automatic fire(input logic [31:0] a, input logic [2:0] k, input int e);
    int b;
    b = brk_cnt;
    issue <= 1'b1;
    addr <= a;
    kind <= k;
    @(posedge clock);
    issue <= 1'b0;
    repeat (4) @(posedge clock);
    chk("breaks", 32'(e), 32'(brk_cnt - b));
  endtask : fire
  task automatic t_reset;
    rchk(PCBRK_ADDR_OFS, 32'(PCBRK_ADDR_RST));
    rchk(PCBRK_CTRL_OFS, 32'(PCBRK_CTRL_RST));
    rchk(PCBRK_STOP_OFS, 32'(PCBRK_STOP_RST));
    rchk(24'hfffa10, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_break;
    bus(1'b1, PCBRK_ADDR_OFS, BRK);
    bus(1'b1, PCBRK_CTRL_OFS, CFG);
    bus(1'b1, PCBRK_IEN_OFS, 32'h1);
    fire(BRK, 3'h7, 0);
    bus(1'b1, PCBRK_STOP_OFS, 32'h0);
    fire(BRK, 3'h7, 1);
    chk("irq", 32'h1, 32'(irq));
    rchk(PCBRK_CTRL_OFS, CFG | 32'h8000);
    fire(BRK + 32'h4, 3'h7, 0);
    fire(BRK, 3'h3, 0);
    fire(BRK, 3'h5, 0);
    $display("test break done");
  endtask : t_break
  task automatic t_clear;
    bus(1'b1, PCBRK_CTRL_OFS, 32'hffff);
    rchk(PCBRK_CTRL_OFS, 32'(PCBRK_CTRL_MASK));
    bus(1'b1, PCBRK_CTRL_OFS, 32'h7fff);
    rchk(PCBRK_CTRL_OFS, 32'(PCBRK_CTRL_MASK & 16'h7fff));
    bus(1'b1, PCBRK_ICLR_OFS, 32'h3);
    rchk(PCBRK_STAT_OFS, 32'h0);
    rchk(PCBRK_ICLR_OFS, 32'h0);
    bus(1'b1, PCBRK_IEN_OFS, 32'h0);
    bus(1'b1, PCBRK_CTRL_OFS, CFG);
    fire(BRK, 3'h7, 1);
    chk("masked irq", 32'h0, 32'(irq));
    rchk(PCBRK_STAT_OFS, 32'h1);
    bus(1'b1, PCBRK_STOP_OFS, 32'h1);
    rchk(PCBRK_STAT_OFS, 32'h3);
    bus(1'b1, PCBRK_STOP_OFS, 32'h0);
    $display("test clear done");
  endtask : t_clear
  task automatic t_rdsel;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, PCBRK_CTRL_OFS, CFG | 32'(s << 2));
      for (int r = 0; r < 2; r++) begin
        fire(BRK, {2'h3, r[0]}, int'(s == 0 || (s == 1 && r == 1) || (s == 2 && r == 0)));
      end
    end
    $display("test read select done");
  endtask : t_rdsel
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Clock, reset and the sequence of tests.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_break();
    t_clear();
    t_rdsel();
    conclude();
  end
endmodule : pcbrk_channel_tb_top
`default_nettype wire
